// ==== dv/ccc_batt_model.sv ====
`timescale 1ns/1ns
module ccc_batt_model
  import ccc_pkg::*;
#(
  parameter int LIFT = 40
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Charger side
  input  wire logic charge_on_i,
  input  wire logic dead_i,
  input  wire logic status_o_i,
  input  wire logic status_oe_i,
  input  wire logic input_good_out_o_i,
  input  wire logic input_good_out_oe_i,
  // Battery and indicator levels
  output logic      above_exit_o,
  output logic      status_pin_o,
  output logic      input_good_pin_o
);
  int level;

  ////////////////////////////////////////////////////////////////////////////
  // Cell voltage rises only while charge flows; a dead cell never lifts
  always_ff @(posedge core_clk_i) begin
    if (rst_i || dead_i) begin
      level <= 0;
    end else if (charge_on_i && level < LIFT) begin
      level <= level + 1;
    end
  end

  assign above_exit_o = (level >= LIFT);

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain lines with pull-ups
  assign status_pin_o     = status_oe_i ? status_o_i : 1'b1;
  assign input_good_pin_o = input_good_out_oe_i ? input_good_out_o_i : 1'b1;
endmodule

// ==== dv/tb_charge_cycle_controller.sv ====
`timescale 1ns/1ns
module tb_charge_cycle_controller
  import ccc_pkg::*;
;
  localparam int          PRE  = 200;
  localparam int          FAST = 2000;
  localparam int          SS   = 8;
  localparam logic [19:0] BASE = 20'hE6822;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        dead       = 1'b1;
  logic [19:0] drv        = 20'h00000;
  logic        lifted;
  ccc_sense_t  sense;
  logic        in_sw, bat_sw, slp, chg, pre, hs, ls, ps;
  logic        st, st_oe, pg, pg_oe, fault, st_pin, pg_pin;
  logic [3:0]  cur;
  int          n_errors    = 0;
  int          comparisons = 0;

  always #10 core_clk_i = ~core_clk_i;
  assign sense = drv | {11'h000, lifted, 8'h00};

  ccc_controller #(.PRECHG_CNT(PRE), .FAST_CNT(FAST), .PWRUP_CNT(10), .SS_CNT(SS),
    .BLINK_CNT(5)) ccc_controller_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sense_i(sense),
    .input_path_switch_o(in_sw), .battery_path_switch_o(bat_sw), .sleep_o(slp),
    .charge_on_o(chg), .precharge_mode_o(pre), .cur_eighths_o(cur), .high_side_o(hs),
    .low_side_o(ls), .period_start_o(ps), .status_o(st), .status_oe_o(st_oe),
    .input_good_out_o(pg), .input_good_out_oe_o(pg_oe), .fault_o(fault));

  ccc_batt_model ccc_batt_model_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .charge_on_i(chg), .dead_i(dead),
    .status_o_i(st), .status_oe_i(st_oe), .input_good_out_o_i(pg),
    .input_good_out_oe_i(pg_oe), .above_exit_o(lifted), .status_pin_o(st_pin),
    .input_good_pin_o(pg_pin));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic put(input logic [19:0] v);
    @(posedge core_clk_i);
    drv <= v;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Restart a cycle by toggling charge allow
  task automatic fresh(input logic d);
    put(BASE & 20'h7FFFF);
    dead <= d;
    tick(8);
    put(BASE);
    tick(24);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_power_path();
    chk(in_sw, 0, "input path at reset");
    chk(bat_sw, 1, "battery path at reset");
    put(BASE & ~20'h40000);
    tick(10);
    chk(slp, 1, "sleep on battery");
    put(BASE & ~20'h20000);
    tick(30);
    chk(chg, 0, "lockout keeps off");
    chk(in_sw, 0, "lockout path off");
    chk(pg_pin, 1, "input good released");
    fresh(1'b1);
    chk(slp, 0, "awake on adapter");
    chk(in_sw, 1, "input path on");
    chk(bat_sw, 0, "battery path off");
    chk(chg, 1, "precharge runs");
    chk(pre, 1, "precharge regulation");
    chk(cur, 0, "no fast target");
    chk(st_pin, 0, "charging pin low");
    chk(pg_pin, 0, "input good pin low");
  endtask

  task automatic t_stops();
    logic [19:0] m [9] = '{20'h80000, 20'h40000, 20'h10000, 20'h08000, 20'h04000,
                           20'h02000, 20'h00400, 20'h00020, 20'h00010};
    foreach (m[i]) begin
      fresh(1'b1);
      chk(chg, 1, "enabled");
      put(BASE ^ m[i]);
      tick(10);
      chk(chg, 0, "stop condition");
    end
    fresh(1'b1);
    put(BASE | 20'h01000);
    tick(10);
    chk(chg, 0, "overtemp stops");
    put(BASE & ~20'h00800);
    tick(10);
    chk(chg, 0, "hysteresis holds");
    put(BASE);
    tick(80);
    chk(chg, 1, "resumes when cooled");
  endtask

  task automatic t_pre_timeout();
    int t;
    logic p;
    fresh(1'b1);
    tick(PRE - 30);
    chk(fault, 0, "no early fault");
    tick(40);
    chk(chg, 0, "precharge expiry");
    chk(fault, 1, "fault shown");
    t = 0;
    p = st_oe;
    repeat (20) begin
      tick(1);
      t += (st_oe !== p);
      p = st_oe;
    end
    chk(t >= 3, 1, "status blinks");
    fresh(1'b1);
    chk(fault, 0, "fault cleared by allow");
    chk(chg, 1, "new cycle");
  endtask

  task automatic t_soft_start();
    int k;
    fresh(1'b0);
    k = 0;
    while (cur !== 4'h1 && k < 300) begin
      tick(1);
      k++;
    end
    chk(pre, 0, "left precharge");
    chk(cur, 1, "first step");
    for (int i = 2; i <= 8; i++) begin
      tick(SS);
      chk(cur, 12'(i), "soft start step");
    end
    put(BASE | 20'h00200);
    tick(8);
    chk(cur, REDUCED_TGT, "cool or warm");
    put(BASE);
  endtask

  task automatic t_term();
    put(BASE | 20'h00044);
    tick(10);
    chk(chg, 1, "below recharge level");
    put(BASE | 20'h00084);
    tick(10);
    chk(chg, 1, "current still high");
    put(BASE | 20'h000C4);
    tick(10);
    chk(chg, 0, "termination");
    put(BASE);
    tick(40);
    chk(chg, 1, "recharge cycle");
  endtask

  task automatic t_fast_timer();
    fresh(1'b0);
    put(BASE | 20'h00008);
    tick(FAST * 3 / 4);
    put(BASE);
    tick(FAST / 2);
    chk(chg, 1, "timer paused");
    tick(FAST * 11 / 20);
    chk(chg, 0, "fast timer expiry");
    chk(fault, 1, "timer fault");
  endtask

  task automatic t_pwm();
    int k;
    fresh(1'b0);
    k = 0;
    while (ps !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    k = 0;
    do begin
      tick(1);
      k++;
    end while (ps !== 1'b1 && k < 400);
    chk(12'(k), 12'(PERIOD_CYC), "switching period");
    tick(3);
    chk(hs, 1, "full on above ramp");
    put(BASE & ~20'h00002);
    tick(400);
    chk({hs, ls}, 0, "zero duty below ramp");
    put(BASE | 20'h00001);
    k = 0;
    while (ls !== 1'b1 && k < 1000) begin
      tick(1);
      k++;
    end
    chk(k > 3 * PERIOD_CYC && k <= 4 * PERIOD_CYC + 10, 1, "refresh delay");
    k = 0;
    while (ls === 1'b1 && k < 20) begin
      chk(hs, 0, "high side off in refresh");
      tick(1);
      k++;
    end
    chk(12'(k), 12'(REFRESH_CYC), "refresh width");
    put(BASE);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    tick(2);
    t_power_path();
    t_stops();
    t_pre_timeout();
    t_soft_start();
    t_term();
    t_pwm();
    t_fast_timer();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end
endmodule

// ==== rtl/ccc_controller.sv ====
`timescale 1ns/1ns
module ccc_controller
  import ccc_pkg::*;
#(
  parameter longint PRECHG_CNT = PRECHG_CYC,
  parameter longint FAST_CNT   = FAST_CYC,
  parameter longint PWRUP_CNT  = PWRUP_CYC,
  parameter longint SS_CNT     = SS_STEP_CYC,
  parameter longint BLINK_CNT  = BLINK_CYC
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Analog comparator and monitor levels
  input  wire ccc_sense_t sense_i,
  // Power path and converter
  output logic            input_path_switch_o,
  output logic            battery_path_switch_o,
  output logic            sleep_o,
  output logic            charge_on_o,
  output logic            precharge_mode_o,
  output logic [3:0]      cur_eighths_o,
  output logic            high_side_o,
  output logic            low_side_o,
  output logic            period_start_o,
  // Status pins, open drain, and a plain fault flag
  output logic            status_o,
  output logic            status_oe_o,
  output logic            input_good_out_o,
  output logic            input_good_out_oe_o,
  output logic            fault_o
);

  ccc_sense_t       s;
  logic [SENSE_W-1:0] s_bits;
  ccc_state_t       state;
  ccc_state_t       next_state;
  logic             die_ot;
  logic             sleep;
  logic             en_ok;
  logic             keep_ok;
  logic             active;
  logic             run;
  logic             pause;
  logic             ce_q;
  logic             ce_rise;
  logic             delay_done;
  logic [CNT_W-1:0] pwrup_cnt;
  logic [CNT_W-1:0] pre_cnt;
  logic [CNT_W-1:0] fast_cnt;
  logic [CNT_W-1:0] ss_cnt;
  logic [CNT_W-1:0] blink_cnt;
  logic [2:0]       ss_step;
  logic             blink;
  logic             pre_expired;
  logic             fast_expired;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  ccc_sync #(.W(SENSE_W)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (sense_i),
    .sync_o     (s_bits)
  );

  assign s = s_bits;

  ////////////////////////////////////////////////////////////////////////////
  // Qualification
  assign sleep   = !s.supply_above_neg;
  assign en_ok   = s.charge_allow && !s.low_supply_mode && !sleep
                   && !s.input_overvoltage && delay_done && s.gate_drive_regulator_good
                   && s.vref_good && !die_ot && !s.ts_fault && s.undervoltage_lockout_ok;
  assign keep_ok = en_ok && s.adapter_headroom && !s.regulator_overload;
  assign active  = (state == ST_PRE) || (state == ST_CC) || (state == ST_CV);
  assign run     = active && keep_ok;
  assign pause   = s.battery_overvoltage || die_ot || s.ts_fault;
  assign ce_rise = s.charge_allow && !ce_q;

  assign pre_expired  = (pre_cnt >= CNT_W'(PRECHG_CNT - 1));
  assign fast_expired = (fast_cnt >= CNT_W'(FAST_CNT - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Die overtemperature with hysteresis
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      die_ot <= 1'b0;
    end else if (s.die_hot) begin
      die_ot <= 1'b1;
    end else if (s.die_cooled) begin
      die_ot <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up delay
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !s.undervoltage_lockout_ok) begin
      pwrup_cnt  <= '0;
      delay_done <= 1'b0;
    end else if (!delay_done) begin
      pwrup_cnt  <= pwrup_cnt + 1'b1;
      delay_done <= (pwrup_cnt >= CNT_W'(PWRUP_CNT - 1));
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ce_q <= 1'b0;
    end else begin
      ce_q <= s.charge_allow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (en_ok) begin
          if (!s.above_precharge_exit) begin
            next_state = ST_PRE;
          end else if (s.voltage_loop_active) begin
            next_state = ST_CV;
          end else begin
            next_state = ST_CC;
          end
        end
      end
      ST_PRE: begin
        if (pre_expired) begin
          next_state = ST_FAULT;
        end else if (s.above_precharge_exit) begin
          next_state = ST_CC;
        end
      end
      ST_CC: begin
        if (fast_expired) begin
          next_state = ST_FAULT;
        end else if (s.voltage_loop_active) begin
          next_state = ST_CV;
        end
      end
      ST_CV: begin
        if (fast_expired) begin
          next_state = ST_FAULT;
        end else if (run && s.above_recharge && s.below_term_current) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!s.above_recharge) begin
          next_state = ST_IDLE;
        end
      end
      ST_FAULT: begin
        if (ce_rise) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!s.charge_allow || !s.undervoltage_lockout_ok) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Precharge and fast charge timers
  always_ff @(posedge core_clk_i) begin
    if (rst_i || state != ST_PRE) begin
      pre_cnt <= '0;
    end else if (run && !pause) begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || state == ST_IDLE || state == ST_PRE) begin
      fast_cnt <= '0;
    end else if (run && !pause && (state == ST_CC || state == ST_CV)) begin
      fast_cnt <= fast_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft-start stepping
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !run || state == ST_PRE) begin
      ss_cnt  <= '0;
      ss_step <= '0;
    end else if (ss_step != SS_LAST) begin
      if (ss_cnt >= CNT_W'(SS_CNT - 1)) begin
        ss_cnt  <= '0;
        ss_step <= ss_step + 1'b1;
      end else begin
        ss_cnt <= ss_cnt + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault blink
  always_ff @(posedge core_clk_i) begin
    if (rst_i || state != ST_FAULT) begin
      blink_cnt <= '0;
      blink     <= 1'b0;
    end else if (blink_cnt >= CNT_W'(BLINK_CNT - 1)) begin
      blink_cnt <= '0;
      blink     <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      input_path_switch_o   <= 1'b0;
      battery_path_switch_o <= 1'b1;
      sleep_o               <= 1'b0;
      charge_on_o           <= 1'b0;
      precharge_mode_o      <= 1'b0;
      cur_eighths_o         <= ZERO_TGT;
      status_oe_o           <= 1'b0;
      input_good_out_oe_o   <= 1'b0;
      fault_o               <= 1'b0;
    end else begin
      input_path_switch_o   <= !sleep && s.undervoltage_lockout_ok;
      battery_path_switch_o <= sleep || !s.undervoltage_lockout_ok;
      sleep_o               <= sleep;
      charge_on_o           <= run;
      precharge_mode_o      <= run && state == ST_PRE;
      if (!run || state == ST_PRE) begin
        cur_eighths_o <= ZERO_TGT;
      end else if (s.ts_cool_warm) begin
        cur_eighths_o <= REDUCED_TGT;
      end else begin
        cur_eighths_o <= {1'b0, ss_step} + 4'h1;
      end
      status_oe_o           <= run || blink;
      input_good_out_oe_o   <= s.undervoltage_lockout_ok && !sleep && !s.input_overvoltage;
      fault_o               <= state == ST_FAULT;
    end
  end

  assign status_o         = 1'b0;
  assign input_good_out_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Converter stage
  ccc_pwm u_pwm (
    .core_clk_i            (core_clk_i),
    .rst_i                 (rst_i),
    .enable_i              (run),
    .err_above_ramp_i      (s.err_above_ramp),
    .bootstrap_low_i       (s.bootstrap_low),
    .battery_overvoltage_i (s.battery_overvoltage),
    .high_side_o           (high_side_o),
    .low_side_o            (low_side_o),
    .period_start_o        (period_start_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  die_ot_set_a: assert property (s.die_hot |=> die_ot)
    else $error("overtemp not set");
  die_ot_hold_a: assert property (die_ot && !s.die_cooled |=> die_ot)
    else $error("overtemp cleared early");
  sleep_path_a: assert property (sleep |=> !input_path_switch_o && battery_path_switch_o
                                 && sleep_o)
    else $error("sleep path wrong");
  run_gate_a: assert property (!keep_ok |=> !charge_on_o)
    else $error("charging without enable");
  start_pre_a: assert property (state == ST_IDLE && en_ok && !s.above_precharge_exit
                                |=> state == ST_PRE)
    else $error("precharge not selected");
  pre_fault_a: assert property (state == ST_PRE && pre_expired && s.charge_allow
                                && s.undervoltage_lockout_ok |=> state == ST_FAULT ##1 fault_o)
    else $error("precharge timeout missed");
  term_a: assert property (state == ST_CV && run && s.above_recharge && s.below_term_current
                           && !fast_expired |=> state == ST_DONE)
    else $error("termination missed");
  rechg_a: assert property (state == ST_DONE && !s.above_recharge && s.charge_allow
                            |=> state == ST_IDLE)
    else $error("recharge missed");
  pause_a: assert property (pause && state == ST_CC |=> $stable(fast_cnt))
    else $error("timer ran while paused");
  cool_a: assert property (run && state == ST_CC && s.ts_cool_warm
                           |=> cur_eighths_o == REDUCED_TGT)
    else $error("target not reduced");

  pre_cc_c: cover property (state == ST_PRE ##1 state == ST_CC);
  cv_done_c: cover property (state == ST_CV ##1 state == ST_DONE);
  fault_c: cover property (state == ST_FAULT);

endmodule

// ==== rtl/ccc_pkg.sv ====
package ccc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing figures
  localparam longint CLK_HZ         = 50_000_000;
  localparam longint PRECHG_TIME_MIN = 30;
  localparam longint FAST_TIME_HR   = 5;
  localparam longint PWRUP_TIME_MS  = 30;
  localparam longint SS_STEP_TIME_US = 1600;
  localparam longint REFRESH_TIME_NS = 80;
  localparam longint SW_FREQ_KHZ    = 300;
  localparam longint BLINK_TIME_MS  = 500;

  // Derived cycle counts
  localparam longint PRECHG_CYC  = PRECHG_TIME_MIN * 60 * CLK_HZ;
  localparam longint FAST_CYC    = FAST_TIME_HR * 3600 * CLK_HZ;
  localparam longint PWRUP_CYC   = PWRUP_TIME_MS * CLK_HZ / 1000;
  localparam longint SS_STEP_CYC = SS_STEP_TIME_US * CLK_HZ / 1_000_000;
  localparam longint BLINK_CYC   = BLINK_TIME_MS * CLK_HZ / 1000;
  localparam longint REFRESH_CYC = (REFRESH_TIME_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
  localparam longint PERIOD_CYC  = CLK_HZ / (SW_FREQ_KHZ * 1000);

  ////////////////////////////////////////////////////////////////////////////
  // Widths and small counts
  localparam int         CNT_W      = 40;
  localparam int         PER_W      = 8;
  localparam logic [2:0] SS_LAST    = 3'h7;
  localparam logic [1:0] BOOT_MISS  = 2'h3;
  localparam logic [3:0] REDUCED_TGT = 4'h1;
  localparam logic [3:0] ZERO_TGT    = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator and monitor inputs
  typedef struct packed {
    logic charge_allow;
    logic supply_above_neg;
    logic undervoltage_lockout_ok;
    logic low_supply_mode;
    logic input_overvoltage;
    logic gate_drive_regulator_good;
    logic vref_good;
    logic die_hot;
    logic die_cooled;
    logic ts_fault;
    logic ts_cool_warm;
    logic above_precharge_exit;
    logic above_recharge;
    logic below_term_current;
    logic adapter_headroom;
    logic regulator_overload;
    logic battery_overvoltage;
    logic voltage_loop_active;
    logic err_above_ramp;
    logic bootstrap_low;
  } ccc_sense_t;

  localparam int SENSE_W = $bits(ccc_sense_t);

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_CC, ST_CV, ST_DONE, ST_FAULT
  } ccc_state_t;

endpackage

// ==== rtl/ccc_pwm.sv ====
`timescale 1ns/1ns
module ccc_pwm
  import ccc_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic enable_i,
  input  wire logic err_above_ramp_i,
  input  wire logic bootstrap_low_i,
  input  wire logic battery_overvoltage_i,
  // Gate requests
  output logic      high_side_o,
  output logic      low_side_o,
  output logic      period_start_o
);

  logic [PER_W-1:0] per_cnt;
  logic [1:0]       low_periods;
  logic [PER_W-1:0] refresh_cnt;
  logic             refresh;
  logic             start;

  assign start = (per_cnt == PER_W'(PERIOD_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Fixed period oscillator
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      per_cnt <= '0;
    end else begin
      per_cnt <= start ? '0 : per_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bootstrap watch and refresh pulse
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      low_periods <= '0;
      refresh     <= 1'b0;
      refresh_cnt <= '0;
    end else if (refresh) begin
      refresh_cnt <= refresh_cnt + 1'b1;
      if (refresh_cnt == PER_W'(REFRESH_CYC - 1)) begin
        refresh     <= 1'b0;
        low_periods <= '0;
      end
    end else if (start) begin
      if (!bootstrap_low_i) begin
        low_periods <= '0;
      end else if (low_periods == BOOT_MISS) begin
        refresh     <= enable_i;
        refresh_cnt <= '0;
      end else begin
        low_periods <= low_periods + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate outputs
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      high_side_o    <= 1'b0;
      low_side_o     <= 1'b0;
      period_start_o <= 1'b0;
    end else begin
      high_side_o    <= enable_i && err_above_ramp_i && !refresh
                        && !battery_overvoltage_i;
      low_side_o     <= refresh;
      period_start_o <= start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  no_shoot_a: assert property (!(high_side_o && low_side_o))
    else $error("both gates on");
  refresh_len_a: assert property ($rose(low_side_o) |-> low_side_o[*4] ##1 !low_side_o)
    else $error("refresh pulse length wrong");
  zero_duty_a: assert property (!err_above_ramp_i |=> !high_side_o)
    else $error("high side on below ramp");
  period_a: assert property (period_start_o |=> !period_start_o[*8])
    else $error("period too short");
  refresh_c: cover property ($rose(low_side_o));

endmodule

// ==== rtl/ccc_sync.sv ====
`timescale 1ns/1ns
module ccc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  // Pins
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  ////////////////////////////////////////////////////////////////////////////
  // Three stages, change taken when stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          sync_o[i] <= s3[i];
        end
      end
    end
  end

endmodule
